/* rtl/mic_pkg.sv */
// Operation
// RQ1 - Receive delay bit 12 set launches RGMII receive clock 2 ns after data
// RQ2 - Transmit delay bit 11 set delays transmit clock 2 ns; clear means aligned
// RQ3 - Bit 9 set selects RGMII; clear leaves choice to the RMII mode bit
// RQ4 - Without RGMII, bit 5 set selects RMII, clear selects MII
// RQ5 - Bit 7 reports reference clock: one 50 MHz, zero 25 MHz; strap default
// RQ6 - Revision bit 4 set (1.0): carrier-data-valid held until last data, no toggle
// RQ7 - Revision bit clear (1.2, default): carrier-data-valid toggles at packet end
// RQ8 - Bit 3 reports overflow: one normal, zero overflow seen; read clears it
// RQ9 - Bit 2 reports underflow: one normal, zero underflow seen; read clears it
// RQ10 - Bits 1:0 size the RMII receive buffer, default 01, four tolerance codes
// RQ11 - Buffer absorbs 50 MHz clock versus recovered data drift, +-100 ppm
// RQ12 - Strap fields load from sampled pins at reset; writes override until reset
// RQ13 - Software keeps reserved fields at defaults: 15:13=010, bit 6=1, bits 10,8=0
package mic_pkg;
    // Byte offsets on the bus
    localparam logic [3:0] MIC_CTRL_ADDR = 4'h0;
    localparam logic [3:0] MIC_IRQ_STAT_ADDR = 4'h4;
    localparam logic [3:0] MIC_IRQ_MASK_ADDR = 4'h8;
    // Field positions of the control register
    localparam int MIC_RXDLY_BIT = 12;
    localparam int MIC_TXDLY_BIT = 11;
    localparam int MIC_RGMII_BIT = 9;
    localparam int MIC_CLKSEL_BIT = 7;
    localparam int MIC_RMII_BIT = 5;
    localparam int MIC_REV_BIT = 4;
    localparam int MIC_OVF_BIT = 3;
    localparam int MIC_UNF_BIT = 2;
    // Reset values of the fixed fields
    localparam logic [2:0] MIC_RSVD_HI_RST = 3'h2;
    localparam logic [1:0] MIC_EBUF_RST = 2'h1;
    // Interrupt status bits
    localparam int MIC_IRQ_OVF = 0;
    localparam int MIC_IRQ_UNF = 1;
    // Timing: 2 ns delay at 100 MHz rounds up to one cycle
    localparam int MIC_CLK_PERIOD_NS = 10;
    localparam int MIC_DELAY_NS = 2;
    localparam int MIC_DELAY_CYC = (MIC_DELAY_NS + MIC_CLK_PERIOD_NS - 1) / MIC_CLK_PERIOD_NS;
    // Interface modes
    typedef enum logic [1:0] {
        MIC_MODE_MII = 2'b00,
        MIC_MODE_RMII = 2'b01,
        MIC_MODE_RGMII = 2'b10
    } mic_mode_type;
    // Elasticity codes to tolerance in bits
    function automatic logic [2:0] mic_ebuf_tol(input logic [1:0] code);
        case (code)
            2'h0: mic_ebuf_tol = 3'h5;
            2'h1: mic_ebuf_tol = 3'h2;
            2'h2: mic_ebuf_tol = 3'h3;
            default: mic_ebuf_tol = 3'h4;
        endcase
    endfunction
endpackage

/* rtl/mic_ctrl.sv */
// Design decisions made here: the register offsets and register access over Wishbone.
module mic_ctrl (
    // System
    input wire logic sys_clk,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    // Strap pins
    input wire logic strap_rx_delay,
    input wire logic strap_tx_delay,
    input wire logic strap_rgmii,
    input wire logic strap_clk_sel,
    input wire logic strap_rmii,
    // Receive datapath events and carrier
    input wire logic rx_link_clk,
    input wire logic rx_fifo_overflow,
    input wire logic rx_fifo_underflow,
    input wire logic rx_carrier,
    input wire logic rx_data_pending,
    // Configuration out
    output mic_pkg::mic_mode_type mode,
    output logic rx_clk_delay_en,
    output logic tx_clk_delay_en,
    output logic clk_sel_50m,
    output logic [2:0] ebuf_tolerance,
    output logic crs_dv,
    output logic link_clk_rise
);
    import mic_pkg::*;

    logic [15:0] ctrl_reg;
    logic strap_pend_reg;
    logic ovf_seen_reg;
    logic unf_seen_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic [2:0] ovf_sync_reg;
    logic [2:0] unf_sync_reg;
    logic [2:0] crs_sync_reg;
    logic [2:0] pend_sync_reg;
    logic [2:0] lclk_sync_reg;
    logic ovf_prev_reg;
    logic unf_prev_reg;
    logic crs_toggle_reg;
    logic wr_hit;
    logic rd_ctrl;
    logic ovf_evt;
    logic unf_evt;
    logic crs_lvl_reg;
    logic pend_lvl_reg;

    // Three-stage synchronisers; a level counts once stages two and three agree
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ovf_sync_reg <= 3'h0;
            unf_sync_reg <= 3'h0;
            crs_sync_reg <= 3'h0;
            pend_sync_reg <= 3'h0;
            lclk_sync_reg <= 3'h0;
        end else begin
            ovf_sync_reg <= {ovf_sync_reg[1:0], rx_fifo_overflow};
            unf_sync_reg <= {unf_sync_reg[1:0], rx_fifo_underflow};
            crs_sync_reg <= {crs_sync_reg[1:0], rx_carrier};
            pend_sync_reg <= {pend_sync_reg[1:0], rx_data_pending};
            lclk_sync_reg <= {lclk_sync_reg[1:0], rx_link_clk};
        end
    end

    // Filtered levels held while stages disagree
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ovf_prev_reg <= 1'b0;
            unf_prev_reg <= 1'b0;
            crs_lvl_reg <= 1'b0;
            pend_lvl_reg <= 1'b0;
        end else begin
            if (ovf_sync_reg[1] == ovf_sync_reg[2]) begin
                ovf_prev_reg <= ovf_sync_reg[2];
            end
            if (unf_sync_reg[1] == unf_sync_reg[2]) begin
                unf_prev_reg <= unf_sync_reg[2];
            end
            // Carrier and pending share one latency, so no dropout when one hands to the other
            if (crs_sync_reg[1] == crs_sync_reg[2]) begin
                crs_lvl_reg <= crs_sync_reg[2];
            end
            if (pend_sync_reg[1] == pend_sync_reg[2]) begin
                pend_lvl_reg <= pend_sync_reg[2];
            end
        end
    end

    assign ovf_evt = (ovf_sync_reg[1] == ovf_sync_reg[2]) && ovf_sync_reg[2] && !ovf_prev_reg;
    assign unf_evt = (unf_sync_reg[1] == unf_sync_reg[2]) && unf_sync_reg[2] && !unf_prev_reg;

    // Bus decode; low byte lane carries bits 7:0, next lane bits 15:8
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd_ctrl = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == MIC_CTRL_ADDR;

    // Ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Control register; straps land the cycle after reset release
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= {MIC_RSVD_HI_RST, 5'h00, 1'b0, 1'b1, 4'h0, MIC_EBUF_RST};
            strap_pend_reg <= 1'b1;
        end else begin
            strap_pend_reg <= 1'b0;
            if (strap_pend_reg) begin
                ctrl_reg[MIC_RXDLY_BIT] <= strap_rx_delay; // RQ12
                ctrl_reg[MIC_TXDLY_BIT] <= strap_tx_delay; // RQ12
                ctrl_reg[MIC_RGMII_BIT] <= strap_rgmii; // RQ12
                ctrl_reg[MIC_CLKSEL_BIT] <= strap_clk_sel; // RQ5
                ctrl_reg[MIC_RMII_BIT] <= strap_rmii; // RQ12
            end else if (wr_hit && wb_adr_i == MIC_CTRL_ADDR) begin
                // Reserved bits are stored as written; software keeps them at defaults
                if (wb_sel_i[0]) begin
                    ctrl_reg[7:4] <= wb_dat_i[7:4];
                    ctrl_reg[1:0] <= wb_dat_i[1:0]; // RQ10
                end
                if (wb_sel_i[1]) begin
                    ctrl_reg[15:8] <= wb_dat_i[15:8]; // RQ13
                end
            end
        end
    end

    // Sticky flow errors; read clears, a new event in that cycle wins
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ovf_seen_reg <= 1'b0;
            unf_seen_reg <= 1'b0;
        end else begin
            ovf_seen_reg <= ovf_evt | (ovf_seen_reg & !rd_ctrl); // RQ8
            unf_seen_reg <= unf_evt | (unf_seen_reg & !rd_ctrl); // RQ9
        end
    end

    // Interrupt status (write one clears, set wins) and mask
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_stat_reg <= 2'h0;
            irq_mask_reg <= 2'h0;
        end else begin
            irq_stat_reg[MIC_IRQ_OVF] <= ovf_evt | (irq_stat_reg[MIC_IRQ_OVF]
                & !(wr_hit && wb_adr_i == MIC_IRQ_STAT_ADDR && wb_sel_i[0]
                && wb_dat_i[MIC_IRQ_OVF]));
            irq_stat_reg[MIC_IRQ_UNF] <= unf_evt | (irq_stat_reg[MIC_IRQ_UNF]
                & !(wr_hit && wb_adr_i == MIC_IRQ_STAT_ADDR && wb_sel_i[0]
                && wb_dat_i[MIC_IRQ_UNF]));
            if (wr_hit && wb_adr_i == MIC_IRQ_MASK_ADDR && wb_sel_i[0]) begin
                irq_mask_reg <= wb_dat_i[1:0];
            end
        end
    end

    // Read data; error bits read one for normal, zero once seen
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
            if (wb_adr_i == MIC_CTRL_ADDR) begin
                wb_dat_o <= {16'h0000, ctrl_reg[15:4], !ovf_seen_reg, !unf_seen_reg,
                    ctrl_reg[1:0]}; // RQ8 RQ9
            end else if (wb_adr_i == MIC_IRQ_STAT_ADDR) begin
                wb_dat_o <= {30'h0000_0000, irq_stat_reg};
            end else if (wb_adr_i == MIC_IRQ_MASK_ADDR) begin
                wb_dat_o <= {30'h0000_0000, irq_mask_reg};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // Configuration outputs, registered so the MAC pins see glitch-free levels
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mode <= MIC_MODE_MII;
            rx_clk_delay_en <= 1'b0;
            tx_clk_delay_en <= 1'b0;
            clk_sel_50m <= 1'b0;
            ebuf_tolerance <= 3'h2;
            irq <= 1'b0;
        end else begin
            if (ctrl_reg[MIC_RGMII_BIT]) begin
                mode <= MIC_MODE_RGMII; // RQ3
            end else if (ctrl_reg[MIC_RMII_BIT]) begin
                mode <= MIC_MODE_RMII; // RQ4
            end else begin
                mode <= MIC_MODE_MII; // RQ4
            end
            // Pad delay line shifts the clock by MIC_DELAY_NS; aligned when clear
            rx_clk_delay_en <= ctrl_reg[MIC_RXDLY_BIT]; // RQ1
            tx_clk_delay_en <= ctrl_reg[MIC_TXDLY_BIT]; // RQ2
            clk_sel_50m <= ctrl_reg[MIC_CLKSEL_BIT]; // RQ5
            // Smallest code (01) already covers standard frames at 100 ppm
            ebuf_tolerance <= mic_ebuf_tol(ctrl_reg[1:0]); // RQ10 RQ11
            irq <= |(irq_stat_reg & ~irq_mask_reg); // A set mask bit hides its event
        end
    end

    // Carrier-data-valid: rev 1.0 holds through drain, rev 1.2 toggles per falling link edge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            crs_dv <= 1'b0;
            crs_toggle_reg <= 1'b0;
            link_clk_rise <= 1'b0;
        end else begin
            link_clk_rise <= lclk_sync_reg[1] & !lclk_sync_reg[2]; // One pulse per rise
            if (lclk_sync_reg[2] && !lclk_sync_reg[1]) begin
                crs_toggle_reg <= !crs_toggle_reg;
            end
            if (crs_lvl_reg) begin
                crs_dv <= 1'b1;
            end else if (!pend_lvl_reg) begin
                crs_dv <= 1'b0;
            end else if (ctrl_reg[MIC_REV_BIT]) begin
                crs_dv <= 1'b1; // RQ6
            end else begin
                crs_dv <= crs_toggle_reg; // RQ7
            end
        end
    end
endmodule // mic_ctrl

/* verification/mic_ctrl_properties.sv */
module mic_ctrl_properties
    import mic_pkg::*;
(
    // System
    input wire logic sys_clk,
    input wire logic reset,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // Receive side and configuration
    input wire logic rx_carrier,
    input wire mic_mode_type mode,
    input wire logic rx_clk_delay_en,
    input wire logic tx_clk_delay_en,
    input wire logic clk_sel_50m,
    input wire logic [2:0] ebuf_tolerance,
    input wire logic crs_dv,
    input wire logic rx_link_clk,
    input wire logic link_clk_rise
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [2:0] TOL [4] = '{3'h5, 3'h2, 3'h3, 3'h4};
    logic wr0;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Write to control acked at this edge, stored the edge before; outputs checked two edges on
    assign wr0 = wb_ack_o && wb_we_i && wb_adr_i == MIC_CTRL_ADDR;
    property p_ack_once;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
    property p_rx_dly;
        wr0 && wb_sel_i[1] |-> ##2 rx_clk_delay_en == $past(wb_dat_i[12], 2);
    endproperty
    a_rx_dly: assert property (p_rx_dly) else $error("receive delay wrong");
    property p_tx_dly;
        wr0 && wb_sel_i[1] |-> ##2 tx_clk_delay_en == $past(wb_dat_i[11], 2);
    endproperty
    a_tx_dly: assert property (p_tx_dly) else $error("transmit delay wrong");
    property p_rgmii;
        wr0 && wb_sel_i[1] && wb_dat_i[9] |-> ##2 mode == MIC_MODE_RGMII;
    endproperty
    a_rgmii: assert property (p_rgmii) else $error("rgmii not selected");
    property p_rmii;
        wr0 && (&wb_sel_i[1:0]) && !wb_dat_i[9] |-> ##2 mode == ($past(wb_dat_i[5], 2)
            ? MIC_MODE_RMII : MIC_MODE_MII);
    endproperty
    a_rmii: assert property (p_rmii) else $error("rmii or mii wrong");
    property p_clk_sel;
        wr0 && wb_sel_i[0] |-> ##2 clk_sel_50m == $past(wb_dat_i[7], 2);
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock select wrong");
    property p_ebuf;
        wr0 && wb_sel_i[0] |-> ##2 ebuf_tolerance == TOL[$past(wb_dat_i[1:0], 2)];
    endproperty
    a_ebuf: assert property (p_ebuf) else $error("buffer tolerance wrong");
    property p_crs;
        $rose(rx_carrier) |-> ##[1:8] crs_dv;
    endproperty
    a_crs: assert property (p_crs) else $error("carrier valid not raised");
    // Link clock rise reaches the pulse after the three-stage synchroniser
    property p_lclk;
        $rose(rx_link_clk) |-> ##[2:4] link_clk_rise;
    endproperty
    a_lclk: assert property (p_lclk) else $error("link clock rise missed");
endmodule // mic_ctrl_properties

bind mic_ctrl mic_ctrl_properties u_props (.*);

/* verification/mic_mac_model.sv */
module mic_mac_model (
    // System
    input wire logic sys_clk,
    // Receive side levels
    output logic rx_link_clk,
    output logic rx_fifo_overflow,
    output logic rx_fifo_underflow,
    output logic rx_carrier,
    output logic rx_data_pending
);
    timeunit 1ns;
    timeprecision 100ps;
    logic run = 1'b0;
    // Link clock stands at low outside frames; odd offset keeps it off sys_clk phase
    initial begin
        {rx_link_clk, rx_fifo_overflow, rx_fifo_underflow, rx_carrier, rx_data_pending} = '0;
        #3;
        forever #40 rx_link_clk = run & ~rx_link_clk;
    end
    // Fifo event as a short level, seen as one rising edge
    task automatic pulse(input int k);
        @(posedge sys_clk);
        if (k == 0) rx_fifo_overflow <= 1'b1;
        else rx_fifo_underflow <= 1'b1;
        repeat (4) @(posedge sys_clk);
        {rx_fifo_overflow, rx_fifo_underflow} <= 2'b00;
    endtask
    // Carrier first, then trailing data after carrier drops
    task automatic frame_start;
        @(posedge sys_clk);
        {rx_carrier, run} <= 2'b11;
        repeat (20) @(posedge sys_clk);
        {rx_carrier, rx_data_pending} <= 2'b01;
    endtask
    task automatic frame_end;
        @(posedge sys_clk);
        {rx_data_pending, run} <= 2'b00;
    endtask
endmodule // mic_mac_model

/* verification/mic_ctrl_tb.sv */
module mic_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import mic_pkg::*;
    localparam logic [2:0] TOL [4] = '{3'h5, 3'h2, 3'h3, 3'h4};
    logic sys_clk = 0, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [3:0] wb_adr_i = '0, wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
    logic strap_rx_delay = 0, strap_tx_delay = 0, strap_rgmii = 0, strap_clk_sel = 0;
    logic strap_rmii = 0, wb_ack_o, irq, rx_clk_delay_en, tx_clk_delay_en, clk_sel_50m;
    logic crs_dv, link_clk_rise, rx_link_clk, rx_fifo_overflow, rx_fifo_underflow;
    logic rx_carrier, rx_data_pending;
    logic [2:0] ebuf_tolerance;
    mic_mode_type mode;
    int err_count = 0, num_checks = 0;
    mic_ctrl dut (.*);
    mic_mac_model mac (.*);
    initial forever #5 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
        int n;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, w, a, 4'h3};
        wb_dat_i <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            give_verdict;
        end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // Reset with straps {rx, tx, rgmii, clk, rmii}, then check defaults
    task automatic t_straps(input logic [4:0] s);
        @(posedge sys_clk);
        reset <= 1'b1;
        {strap_rx_delay, strap_tx_delay, strap_rgmii, strap_clk_sel, strap_rmii} <= s;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk("mode", 16'(mode), s[2] ? 16'(MIC_MODE_RGMII) : 16'(s[0]));
        chk("dly", {14'h0, rx_clk_delay_en, tx_clk_delay_en}, {14'h0, s[4:3]});
        chk("c50", 16'(clk_sel_50m), 16'(s[1]));
        wb(0, MIC_CTRL_ADDR, 16'h0000);
        chk("ctrl", rd[15:0] & 16'hfff3, {3'h2, s[4:3], 1'b0, s[2], 1'b0, s[1], 1'b1, s[0],
            5'h01});
    endtask
    // Every mode, delay and buffer code; reserved fields kept at defaults
    task automatic t_modes;
        logic [15:0] v;
        for (int i = 0; i < 4; i++) begin
            v = {3'h2, i[0], i[1], 1'b0, i[1], 1'b0, i[0], 1'b1, i[0], 3'h0, i[1:0]};
            wb(1, MIC_CTRL_ADDR, v);
            wb(0, MIC_CTRL_ADDR, 16'h0000);
            chk("rdback", rd[15:0] & 16'hfff3, v);
            chk("mode", 16'(mode), i[1] ? 16'(MIC_MODE_RGMII) : 16'(i[0]));
            chk("tol", 16'(ebuf_tolerance), 16'(TOL[i]));
            chk("dly", {14'h0, rx_clk_delay_en, tx_clk_delay_en}, {14'h0, i[0], i[1]});
        end
        wb(1, 4'hc, 16'hffff);
        wb(0, 4'hc, 16'h0000);
        chk("unmapped", rd[15:0], 16'h0000);
        wb(0, MIC_CTRL_ADDR, 16'h0000);
        chk("ctrl kept", rd[15:0] & 16'hfff3, 16'h5ae3);
    endtask
    // Fifo event: sticky status, mask, clear-on-read control bit, write-one clear
    task automatic t_event(input int k);
        mac.pulse(k);
        repeat (6) @(posedge sys_clk);
        wb(1, MIC_IRQ_MASK_ADDR, 16'h0003);
        repeat (3) @(posedge sys_clk);
        chk("irq masked", 16'(irq), 16'h0000);
        wb(1, MIC_IRQ_MASK_ADDR, 16'h0000);
        repeat (3) @(posedge sys_clk);
        chk("irq", 16'(irq), 16'h0001);
        wb(0, MIC_IRQ_STAT_ADDR, 16'h0000);
        chk("stat", rd[15:0], 16'(1 << k));
        wb(0, MIC_CTRL_ADDR, 16'h0000);
        chk("seen", 16'(rd[3 - k]), 16'h0000);
        wb(0, MIC_CTRL_ADDR, 16'h0000);
        chk("cleared", 16'(rd[3 - k]), 16'h0001);
        wb(1, MIC_IRQ_STAT_ADDR, 16'(1 << k));
        repeat (3) @(posedge sys_clk);
        chk("irq off", 16'(irq), 16'h0000);
    endtask
    // Trailing data after carrier: held in revision 1.0, toggling in 1.2
    task automatic t_crs(input logic rev);
        int tg;
        int nr;
        logic last;
        tg = 0;
        nr = 0;
        wb(1, MIC_CTRL_ADDR, {11'h203, rev, 4'h1});
        // Watch from before carrier drops so a dropout at carrier end is caught
        fork
            mac.frame_start();
        join_none
        repeat (8) @(posedge sys_clk);
        chk("crs on", 16'(crs_dv), 16'h0001);
        last = crs_dv;
        repeat (50) begin
            @(posedge sys_clk);
            if (crs_dv !== last) tg++;
            if (link_clk_rise === 1'b1) nr++;
            last = crs_dv;
        end
        chk("toggled", 16'(tg > 0), 16'(!rev));
        chk("link rises", 16'(nr >= 6 && nr <= 7), 16'h0001);
        if (rev) chk("held", 16'(crs_dv), 16'h0001);
        mac.frame_end();
        repeat (8) @(posedge sys_clk);
        chk("crs end", 16'(crs_dv), 16'h0000);
    endtask
    initial begin
        t_straps(5'b10011);
        t_modes();
        t_straps(5'b10011);
        t_straps(5'b01100);
        t_event(0);
        t_event(1);
        t_crs(1'b1);
        t_crs(1'b0);
        give_verdict();
    end
endmodule // mic_ctrl_tb
